//--- logic/sspb_bridge.sv
// i2c register slave with slot status, busy tallies and pll spi bridge
`timescale 1ns/1ps
module sspb_bridge #(
   parameter int NSLOT = sspb_pkg::NSLOT,
   parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary i2c address
   parameter int SPI_HALF = sspb_pkg::SPI_HALF_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic [sspb_pkg::NSLOT-1:0] PAYLOAD_HOLD_LINE_I,
   input wire logic [sspb_pkg::NSLOT-1:0] PAYLOAD_FIRE_LINE_I,
   output logic SPI_SCLK_O,
   output logic SPI_MOSI_O,
   output logic SPI_CS_N_O,
   input wire logic SPI_MISO_I,
   output logic SPI_BUSY_O
);
   import sspb_pkg::*;

   generate
      if (NSLOT != sspb_pkg::NSLOT) begin : g_bad
         $error("slot count must match the port width");
      end
   endgenerate

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TXACK = 3'b100,
      ST_TXGO = 3'b101
   } sspb_state_e;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [NSLOT-1:0] hold_m, hold_s, fire_m, fire_s;
   logic [NSLOT-1:0] busy_lvl_reg, trig_lvl_reg;

   always_ff @(posedge CLK_I) begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      hold_m <= PAYLOAD_HOLD_LINE_I;
      hold_s <= hold_m;
      fire_m <= PAYLOAD_FIRE_LINE_I;
      fire_s <= fire_m;
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         busy_lvl_reg <= RST_WORD[NSLOT-1:0];
         trig_lvl_reg <= RST_WORD[NSLOT-1:0];
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         busy_lvl_reg <= hold_s;
         trig_lvl_reg <= fire_s;
      end
   end

   wire scl_rise = scl_s && !scl_d;
   wire scl_fall = !scl_s && scl_d;
   wire start_det = scl_s && scl_d && sda_d && !sda_s;
   wire stop_det = scl_s && scl_d && !sda_d && sda_s;

   // ***************************************************************
   // busy assertion tallies
   // ***************************************************************
   logic [WORD_W-1:0] tally_reg [NSLOT];
   logic [NSLOT-1:0] tally_clr;
   logic [7:0] ptr_reg;
   logic rd_load;

   wire tally_hit = (ptr_reg >= OFF_TALLY_FIRST) &&
      ((ptr_reg < OFF_TALLY_FIRST + 8'(NSLOT)) ||
       (ptr_reg == OFF_TALLY_LAST));
   wire [7:0] tally_off = ptr_reg - OFF_TALLY_FIRST;
   wire [3:0] tally_idx = (ptr_reg == OFF_TALLY_LAST) ?
      4'(NSLOT - 1) : tally_off[3:0];

   genvar gi;
   generate
      for (gi = 0; gi < NSLOT; gi++) begin : g_tally
         wire rise = hold_s[gi] && !busy_lvl_reg[gi];
         wire sat = tally_reg[gi] == TALLY_MAX;
         assign tally_clr[gi] = rd_load && tally_hit &&
            (tally_idx == 4'(gi));
         always_ff @(posedge CLK_I) begin
            if (SRST_I) begin
               tally_reg[gi] <= RST_WORD;
            end else if (tally_clr[gi]) begin
               tally_reg[gi] <= rise ? TALLY_ONE : RST_WORD;
            end else if (rise && !sat) begin
               tally_reg[gi] <= tally_reg[gi] + TALLY_ONE;
            end
         end
      end
   endgenerate

   // ***************************************************************
   // read selection
   // ***************************************************************
   logic [7:0] pll_hold_reg;
   logic [WORD_W-1:0] rd_word;

   assign rd_word =
      (ptr_reg == OFF_BUSY_LVL) ? WORD_W'(busy_lvl_reg) :
      (ptr_reg == OFF_TRIG_LVL) ? WORD_W'(trig_lvl_reg) :
      tally_hit ? tally_reg[tally_idx] :
      (ptr_reg == OFF_PLL_HOLD) ? {8'h00, pll_hold_reg} :
      RST_WORD;

   // ***************************************************************
   // i2c slave
   // ***************************************************************
   sspb_state_e st_reg, st_next;
   logic [3:0] bit_reg, bit_next;
   logic [2:0] idx_reg, idx_next;
   logic [7:0] sh_reg, sh_next, ptr_next, hi_reg, hi_next;
   logic rw_reg, rw_next, lo_reg, lo_next;
   logic [WORD_W-1:0] rdw_reg, rdw_next;
   logic spi_go, spi_busy, spi_done, pll_rd_reg;
   logic [7:0] spi_rdata;

   wire addr_ok = (sh_reg[7:1] == DEV_ADDR) && !spi_busy;
   wire is_cmd = (ptr_reg == CMD_PLL_WR) || (ptr_reg == CMD_PLL_RD);

   always_comb begin
      st_next = st_reg;
      bit_next = bit_reg;
      idx_next = idx_reg;
      sh_next = sh_reg;
      ptr_next = ptr_reg;
      hi_next = hi_reg;
      rw_next = rw_reg;
      lo_next = lo_reg;
      rdw_next = rdw_reg;
      spi_go = 1'b0;
      rd_load = 1'b0;
      if (start_det) begin
         st_next = ST_RX;
         bit_next = 4'h0;
         idx_next = IDX_DEV;
      end else if (stop_det) begin
         st_next = ST_IDLE;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_next = {sh_reg[6:0], sda_s};
                  bit_next = bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == BYTE_BITS) begin
                  st_next = ST_ACK;
                  if (idx_reg == IDX_DEV) begin
                     rw_next = sh_reg[0];
                     if (!addr_ok) st_next = ST_IDLE;
                  end else if (idx_reg == IDX_PTR) begin
                     ptr_next = sh_reg;
                  end else if (idx_reg == IDX_HI) begin
                     hi_next = sh_reg;
                  end else if (idx_reg == IDX_LO) begin
                     spi_go = is_cmd;
                  end else begin
                     st_next = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_next = 4'h0;
                  if (rw_reg) begin
                     st_next = ST_TX;
                     rd_load = 1'b1;
                     rdw_next = rd_word;
                     sh_next = rd_word[15:8];
                     lo_next = 1'b1;
                  end else begin
                     st_next = ST_RX;
                     if (idx_reg != IDX_OVER) idx_next = idx_reg + 3'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_reg == LAST_BIT) begin
                     st_next = ST_TXACK;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     bit_next = bit_reg + 4'h1;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) st_next = sda_s ? ST_IDLE : ST_TXGO;
            end
            ST_TXGO: begin
               if (scl_fall) begin
                  st_next = ST_TX;
                  bit_next = 4'h0;
                  sh_next = lo_reg ? rdw_reg[7:0] : rdw_reg[15:8];
                  lo_next = !lo_reg;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         st_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         idx_reg <= IDX_DEV;
         sh_reg <= 8'h00;
         ptr_reg <= 8'h00;
         hi_reg <= 8'h00;
         rw_reg <= 1'b0;
         lo_reg <= 1'b0;
         rdw_reg <= RST_WORD;
      end else begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         idx_reg <= idx_next;
         sh_reg <= sh_next;
         ptr_reg <= ptr_next;
         hi_reg <= hi_next;
         rw_reg <= rw_next;
         lo_reg <= lo_next;
         rdw_reg <= rdw_next;
      end
   end

   // open drain: only ever pulls low
   assign SDA_O = 1'b0;
   assign SDA_OE_O = (st_reg == ST_ACK) ||
      ((st_reg == ST_TX) && !sh_reg[7]);

   // ***************************************************************
   // pll spi bridge
   // ***************************************************************
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         pll_rd_reg <= 1'b0;
         pll_hold_reg <= 8'h00;
      end else begin
         if (spi_go) pll_rd_reg <= (ptr_reg == CMD_PLL_RD);
         if (spi_done && pll_rd_reg) pll_hold_reg <= spi_rdata;
      end
   end

   sspb_spi_master #(
      .HALF_CYC(SPI_HALF)
   ) u_spi (
      .CLK_I(CLK_I),
      .SRST_I(SRST_I),
      .go_i(spi_go),
      .rd_i(ptr_reg == CMD_PLL_RD),
      .addr_i(hi_reg),
      .data_i(sh_reg),
      .miso_i(SPI_MISO_I),
      .busy_o(spi_busy),
      .done_o(spi_done),
      .rdata_o(spi_rdata),
      .sclk_o(SPI_SCLK_O),
      .mosi_o(SPI_MOSI_O),
      .cs_n_o(SPI_CS_N_O)
   );

   assign SPI_BUSY_O = spi_busy;

endmodule : sspb_bridge

//--- logic/sspb_pkg.sv
// constants and register map of the slot status and pll spi bridge
package sspb_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int NSLOT = 16;
   localparam int WORD_W = 16;
   localparam logic [7:0] OFF_BUSY_LVL = 8'h06;
   localparam logic [7:0] OFF_TRIG_LVL = 8'h07;
   localparam logic [7:0] OFF_TALLY_FIRST = 8'h08;
   localparam logic [7:0] OFF_TALLY_LAST = 8'h18;
   localparam logic [7:0] OFF_PLL_HOLD = 8'h19;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] TALLY_MAX = 16'hffff;
   localparam logic [15:0] TALLY_ONE = 16'h0001;

   // ***************************************************************
   // i2c framing
   // ***************************************************************
   localparam logic [7:0] CMD_PLL_WR = 8'h20;
   localparam logic [7:0] CMD_PLL_RD = 8'h21;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [2:0] IDX_DEV = 3'h0;
   localparam logic [2:0] IDX_PTR = 3'h1;
   localparam logic [2:0] IDX_HI = 3'h2;
   localparam logic [2:0] IDX_LO = 3'h3;
   localparam logic [2:0] IDX_OVER = 3'h4;

   // ***************************************************************
   // spi framing and timing
   // ***************************************************************
   localparam logic [7:0] SPI_LEAD = 8'h00;
   localparam logic [7:0] SPI_DIR_RD = 8'h80;
   localparam logic [7:0] SPI_DIR_WR = 8'h40;
   localparam logic [5:0] SPI_LAST_BIT = 6'h1f;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SPI_HALF_NS = 320;
   localparam int SPI_HALF_CYC =
      (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : sspb_pkg

//--- logic/sspb_spi_master.sv
// spi master that sends one four byte pll frame
`timescale 1ns/1ps
module sspb_spi_master #(
   parameter int HALF_CYC = sspb_pkg::SPI_HALF_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic go_i,
   input wire logic rd_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic miso_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic cs_n_o
);
   import sspb_pkg::*;

   generate
      if (HALF_CYC < 1 || HALF_CYC > 65535) begin : g_bad
         $error("spi half period out of range");
      end
   endgenerate

   logic [15:0] div_reg;
   logic tick;
   logic [31:0] frame_reg;
   logic [5:0] bit_reg;
   logic [7:0] rx_reg;
   logic miso_m, miso_s;
   logic [7:0] dir_byte;

   assign tick = busy_o && (div_reg == 16'(HALF_CYC - 1));
   assign dir_byte = rd_i ? SPI_DIR_RD : SPI_DIR_WR;
   assign mosi_o = frame_reg[31];
   assign rdata_o = rx_reg;

   always_ff @(posedge CLK_I) begin
      miso_m <= miso_i;
      miso_s <= miso_m;
   end

   always_ff @(posedge CLK_I) begin
      done_o <= 1'b0;
      if (SRST_I) begin
         busy_o <= 1'b0;
         cs_n_o <= 1'b1;
         sclk_o <= 1'b0;
         div_reg <= 16'h0000;
         bit_reg <= 6'h00;
         frame_reg <= 32'h0000_0000;
         rx_reg <= 8'h00;
      end else if (go_i && !busy_o) begin
         frame_reg <= {SPI_LEAD, addr_i, dir_byte, data_i};
         busy_o <= 1'b1;
         cs_n_o <= 1'b0;
         div_reg <= 16'h0000;
         bit_reg <= 6'h00;
      end else if (busy_o) begin
         div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
         if (tick && !sclk_o) begin
            sclk_o <= 1'b1;
            rx_reg <= {rx_reg[6:0], miso_s};
         end else if (tick) begin
            sclk_o <= 1'b0;
            frame_reg <= {frame_reg[30:0], 1'b0};
            bit_reg <= bit_reg + 6'h01;
            if (bit_reg == SPI_LAST_BIT) begin
               busy_o <= 1'b0;
               cs_n_o <= 1'b1;
               done_o <= 1'b1;
            end
         end
      end
   end

endmodule : sspb_spi_master

//--- tb/sspb_bridge_bench.sv
// self-checking bench of the slot status and pll spi bridge
`timescale 1ns/1ps
module sspb_bridge_bench;
   import sspb_pkg::*;
   localparam logic [6:0] DEV = 7'h2a;
   logic clk, srst, scl, sda_drv, miso, sclk, mosi, cs_n, busy, sda_o, sda_oe;
   logic [15:0] hold, fire, w;
   logic [7:0] a8, d8;
   logic [7:0] shadow [256];
   logic [3:0] acks;
   logic [2:0] cnt [16];
   int fail_count, comparisons, seed, i, k;
   wire logic sda = sda_drv & ~sda_oe;
   sspb_bridge #(.DEV_ADDR(DEV), .SPI_HALF(4)) u_sspb_bridge (
      .CLK_I(clk), .SRST_I(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .PAYLOAD_HOLD_LINE_I(hold),
      .PAYLOAD_FIRE_LINE_I(fire), .SPI_SCLK_O(sclk), .SPI_MOSI_O(mosi),
      .SPI_CS_N_O(cs_n), .SPI_MISO_I(miso), .SPI_BUSY_O(busy));
   sspb_pll_model u_sspb_pll_model (.SCLK_I(sclk), .MOSI_I(mosi),
      .CS_N_I(cs_n), .MISO_O(miso));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****
   // i2c master
   // ****
   task automatic q;
      repeat (4) @(negedge clk);
   endtask : q
   task automatic start_c;
      sda_drv = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask : start_c
   task automatic stop_c;
      sda_drv = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b1;
      q();
   endtask : stop_c
   // nine bits, the last one is the acknowledge slot
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int b = 8; b >= 0; b--) begin
         sda_drv = tx[b];
         q();
         scl = 1'b1;
         q();
         rx[b] = sda;
         q();
         scl = 1'b0;
         q();
      end
   endtask : xfer
   task automatic wr(input logic [7:0] p, h, l, output logic [3:0] a);
      logic [8:0] r0, r1, r2, r3;
      start_c();
      xfer({DEV, 2'b01}, r0);
      xfer({p, 1'b1}, r1);
      xfer({h, 1'b1}, r2);
      xfer({l, 1'b1}, r3);
      a = {r0[0], r1[0], r2[0], r3[0]};
      stop_c();
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [15:0] d);
      logic [8:0] r;
      start_c();
      xfer({DEV, 2'b01}, r);
      xfer({p, 1'b1}, r);
      start_c();
      xfer({DEV, 2'b11}, r);
      xfer(9'h1fe, r);
      d[15:8] = r[8:1];
      xfer(9'h1ff, r);
      d[7:0] = r[8:1];
      stop_c();
   endtask : rd
   // ****
   // checks
   // ****
   task automatic chk_word(input logic [15:0] g, e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_flag(input logic [3:0] g, e);
      chk_word({12'h000, g}, {12'h000, e});
   endtask : chk_flag
   function automatic logic [15:0] tally_exp(input int s);
      return {13'h0000, cnt[s]};
   endfunction : tally_exp
   task automatic wait_idle;
      for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk);
      chk_flag({3'h0, busy}, 4'h0);
   endtask : wait_idle
   task automatic pll_read(input logic [7:0] a);
      wr(CMD_PLL_RD, a, 8'($random(seed)), acks);
      chk_flag(acks, 4'h0);
      wait_idle();
      rd(OFF_PLL_HOLD, w);
      chk_word(w, {8'h00, shadow[a]});
   endtask : pll_read
   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   // about 50k cycles of bus traffic expected, margin on top
   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      test_done();
   end
   // ****
   // scenarios
   // ****
   initial begin
      seed = 32'he56f;
      {scl, sda_drv, srst} = 3'h7;
      hold = '0;
      fire = '0;
      fail_count = 0;
      comparisons = 0;
      foreach (shadow[j]) shadow[j] = 8'(j) ^ 8'h5a;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      rd(OFF_BUSY_LVL, w);
      chk_word(w, RST_WORD);
      rd(OFF_TRIG_LVL, w);
      chk_word(w, RST_WORD);
      rd(OFF_TALLY_FIRST, w);
      chk_word(w, RST_WORD);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         hold = (i == 0) ? 16'h8001 : 16'($random(seed));
         fire = 16'($random(seed));
         rd(OFF_BUSY_LVL, w);
         chk_word(w, hold);
         rd(OFF_TRIG_LVL, w);
         chk_word(w, fire);
      end
      $display("test levels done");
      hold = '0;
      for (k = 0; k < NSLOT; k++) begin
         rd(OFF_TALLY_FIRST + 8'(k), w);
         cnt[k] = 3'($random(seed) & 3) + 3'h1;
      end
      for (i = 0; i < 4; i++) begin
         for (k = 0; k < NSLOT; k++) hold[k] = (i < cnt[k]);
         repeat (4) @(negedge clk);
         hold = '0;
         repeat (4) @(negedge clk);
      end
      for (k = 0; k < NSLOT; k++) begin
         rd(OFF_TALLY_FIRST + 8'(k), w);
         chk_word(w, tally_exp(k));
      end
      rd(OFF_TALLY_FIRST, w);
      chk_word(w, RST_WORD);
      hold[15] = 1'b1;
      repeat (4) @(negedge clk);
      rd(OFF_TALLY_LAST, w);
      chk_word(w, TALLY_ONE);
      $display("test tally done");
      for (i = 0; i < 3; i++) begin
         a8 = 8'($random(seed));
         d8 = 8'($random(seed));
         pll_read(a8);
         wr(CMD_PLL_WR, a8, d8, acks);
         chk_flag(acks, 4'h0);
         chk_flag({3'h0, busy}, 4'h1);
         wr(OFF_BUSY_LVL, 8'h00, 8'h00, acks);
         chk_flag(acks, 4'hf);
         wait_idle();
         shadow[a8] = d8;
         pll_read(a8);
      end
      $display("test pll done");
      test_done();
   end
endmodule : sspb_bridge_bench

//--- tb/sspb_bridge_properties.sv
// port assertions of the slot status and pll spi bridge
`timescale 1ns/1ps
module sspb_bridge_checker #(
   parameter int SPI_HALF = sspb_pkg::SPI_HALF_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_O,
   input wire logic [sspb_pkg::NSLOT-1:0] PAYLOAD_HOLD_LINE_I,
   input wire logic [sspb_pkg::NSLOT-1:0] PAYLOAD_FIRE_LINE_I,
   input wire logic SPI_SCLK_O,
   input wire logic SPI_MOSI_O,
   input wire logic SPI_CS_N_O,
   input wire logic SPI_MISO_I,
   input wire logic SPI_BUSY_O
);
   // ****
   // frame bit counter
   // ****
   logic sclk_reg;
   logic dir_reg;
   logic [5:0] rise_reg;
   logic [12:0] busy_reg;
   wire logic rise_w = SPI_SCLK_O & ~sclk_reg;
   always_ff @(posedge CLK_I) begin
      sclk_reg <= SPI_SCLK_O;
      rise_reg <= (SRST_I | SPI_CS_N_O) ? 6'h00 : rise_reg + 6'(rise_w);
      busy_reg <= SPI_BUSY_O ? busy_reg + 13'h0001 : 13'h0000;
      if (rise_w && rise_reg == 6'h10) dir_reg <= SPI_MOSI_O;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   sequence s_launch;
      $rose(SPI_BUSY_O);
   endsequence
   sequence s_close;
      $rose(SPI_CS_N_O);
   endsequence
   a_sda_low_only: assert property (SDA_O == 1'b0)
      else $error("sda driven high");
   a_launch_scl_low: assert property (s_launch |-> !SCL_I)
      else $error("spi launched outside scl low");
   a_frame_opens: assert property (s_launch |-> !SPI_CS_N_O
      && !SPI_SCLK_O && !SPI_MOSI_O) else $error("bad frame start");
   a_frame_closes: assert property (s_close |-> !SPI_BUSY_O
      && rise_reg == 6'h20) else $error("frame not 32 bits");
   a_sclk_idle_low: assert property (SPI_CS_N_O |-> !SPI_SCLK_O)
      else $error("sclk moves while deselected");
   a_mosi_on_fall: assert property (!SPI_CS_N_O && $past(!SPI_CS_N_O)
      && !$fell(SPI_SCLK_O) |-> $stable(SPI_MOSI_O))
      else $error("mosi changed off a fall");
   a_zero_bits: assert property (rise_w && (rise_reg < 6'h08
      || (rise_reg > 6'h11 && rise_reg < 6'h18)) |-> !SPI_MOSI_O)
      else $error("frame bit should be zero");
   a_dir_onehot: assert property (rise_w && rise_reg == 6'h11
      |-> SPI_MOSI_O != dir_reg) else $error("bad direction byte");
   a_no_ack_busy: assert property (SPI_BUSY_O && $past(SPI_BUSY_O)
      && !$past(SDA_OE_O) |-> !SDA_OE_O) else $error("ack during spi");
   a_frame_bounded: assert property
      (busy_reg <= 13'(64 * SPI_HALF + 8)) else $error("spi frame too long");
endmodule : sspb_bridge_checker

bind sspb_bridge sspb_bridge_checker #(.SPI_HALF(SPI_HALF)) u_chk (
   .CLK_I(CLK_I), .SRST_I(SRST_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
   .PAYLOAD_HOLD_LINE_I(PAYLOAD_HOLD_LINE_I),
   .PAYLOAD_FIRE_LINE_I(PAYLOAD_FIRE_LINE_I),
   .SPI_SCLK_O(SPI_SCLK_O), .SPI_MOSI_O(SPI_MOSI_O),
   .SPI_CS_N_O(SPI_CS_N_O), .SPI_MISO_I(SPI_MISO_I),
   .SPI_BUSY_O(SPI_BUSY_O));

//--- tb/sspb_pll_model.sv
// pll register file answering four byte spi frames
`timescale 1ns/1ps
module sspb_pll_model (
   input wire logic SCLK_I,
   input wire logic MOSI_I,
   input wire logic CS_N_I,
   output logic MISO_O
);
   // ****
   // frame decode
   // ****
   logic [7:0] mem_reg [256];
   logic [31:0] sh_reg;
   logic [7:0] addr_reg;
   logic rd_reg;
   int bits;
   initial begin
      foreach (mem_reg[j]) mem_reg[j] = 8'(j) ^ 8'h5a;
      MISO_O = 1'b0;
      rd_reg = 1'b0;
      bits = 0;
   end
   always @(negedge CS_N_I) bits = 0;
   always @(posedge SCLK_I) begin
      sh_reg = {sh_reg[30:0], MOSI_I};
      bits++;
      if (bits == 24) begin
         addr_reg = sh_reg[15:8];
         rd_reg = (sh_reg[7:0] == 8'h80 && sh_reg[23:16] == 8'h00);
      end
   end
   // released line toggles so a stale bit is never read as data
   always @(negedge SCLK_I) begin
      if (rd_reg && bits >= 24 && bits < 32)
         MISO_O = mem_reg[addr_reg][31 - bits];
      else MISO_O = ~MISO_O;
   end
   always @(posedge CS_N_I) begin
      if (bits == 32 && sh_reg[31:24] == 8'h00 && sh_reg[15:8] == 8'h40)
         mem_reg[addr_reg] = sh_reg[7:0];
      MISO_O = ~MISO_O;
      rd_reg = 1'b0;
   end
endmodule : sspb_pll_model
